/* hdl/clk_loss_regs.svh */
// Purpose: Offsets, fields, resets and timing counts of the clock monitors
// Assumes: Byte-wide registers on a plain write/read strobe port
// Notes:   Definitions only
`ifndef CLK_LOSS_REGS_SVH
`define CLK_LOSS_REGS_SVH
// ****************************************
// Register offsets
// ****************************************
`define OFS_MON_CTRL      8'h2c
`define OFS_TIMEOUT_ONE   8'h2d
`define OFS_TIMEOUT_TWO   8'h2e
`define OFS_SAMPLE_RATE   8'h2f
`define OFS_RECOVERY      8'h32
`define OFS_STICKY        8'h68
// ****************************************
// Reset values
// ****************************************
`define RST_MON_CTRL      8'h00
`define RST_TIMEOUT_ONE   8'h17
`define RST_TIMEOUT_TWO   8'h00
`define RST_SAMPLE_RATE   8'h00
`define RST_RECOVERY      8'h00
// ****************************************
// Field positions
// ****************************************
`define BIT_RESET_MODE    7
`define BIT_MUTE_SEL      5
`define BIT_SRC_ONE       4
`define BIT_SRC_TWO_HI    3
`define BIT_SRC_TWO_LO    2
`define BIT_EN_ONE        1
`define BIT_EN_TWO        0
`define BIT_REC_TWO       1
`define BIT_REC_ONE       0
`define BIT_STICKY_CL     2
// ****************************************
// Timing: clock 10 MHz, times in microseconds
// ****************************************
`define CLK_MHZ           10
`define TO_US_0           2730
`define TO_US_1           22000
`define TO_US_2           44000
`define TO_US_3           87000
`define TO_US_4           174000
`define TO_US_5           350000
`define TO_US_6           700000
`define TO_US_7           1400000
`define RAMP_US_0         15
`define RAMP_US_1         30
`define RAMP_US_2         60
`define RAMP_US_3         120
`define RAMP_CYC(us)      ((us) * `CLK_MHZ)
`endif

/* hdl/clk_loss_pkg.sv */
// Purpose: Types shared by the clock monitors
// Assumes: Nothing
// Notes:   Values live in clk_loss_regs.svh
package clk_loss_pkg;
  typedef enum logic [2:0] {
    MON_RUN  = 3'b001,
    MON_LOST = 3'b010,
    MON_HOLD = 3'b100
  } mon_state_t;
endpackage

/* hdl/clk_watch.sv */
// Purpose: One clock-loss watchdog on a reference count that saturates at the limit
// Assumes: Watched clock is asynchronous; it is synchronised here
// Notes:   Edge restarts the count; timeout raises a level until recovered
`timescale 1ns/10ps
module clk_watch
  import clk_loss_pkg::*;
#(
  parameter int CW = 24
) (
  input  wire logic          i_sys_clk,
  input  wire logic          i_nrst,
  input  wire logic          i_enable,
  input  wire logic          i_watched,
  input  wire logic [CW-1:0] i_limit,
  input  wire logic          i_recovery_off,
  input  wire logic          i_release,
  output logic               o_lost,
  output logic               o_lost_pulse
);
  logic [2:0]    sync_r;
  logic [CW-1:0] count_r;
  mon_state_t    state_r;
  logic          edge_seen;

  // Two stages, then a third for edge detect
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sync_r <= 3'h0;
    end else begin
      sync_r <= {sync_r[1:0], i_watched};
    end
  end
  assign edge_seen = sync_r[2] ^ sync_r[1];

  // Reference count restarts on every watched edge
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      count_r <= '0;
    end else if (!i_enable || edge_seen || state_r != MON_RUN) begin
      count_r <= '0;
    end else if (count_r < i_limit) begin
      count_r <= count_r + 1'b1;
    end
  end

  // Lost while stopped; auto recovery on the next edge unless suppressed
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_r <= MON_RUN;
    end else if (!i_enable) begin
      state_r <= MON_RUN;
    end else begin
      unique case (state_r)
        MON_RUN:  if (count_r >= i_limit) state_r <= MON_LOST;
        MON_LOST: if (edge_seen) begin
          state_r <= i_recovery_off ? MON_HOLD : MON_RUN;
        end
        MON_HOLD: if (i_release) state_r <= MON_RUN;
      endcase
    end
  end

  assign o_lost = i_enable && (state_r != MON_RUN);
  // Compare at or above so a limit lowered mid-count still fires at once
  assign o_lost_pulse = i_enable && state_r == MON_RUN && count_r >= i_limit;
endmodule

/* hdl/clk_loss_monitor.sv */
// Purpose: Two clock-loss monitors with shutdown, mute and gain ramp
// Assumes: Byte register port on the system clock; clocks from pins
// Notes:   Long timeouts scale by the PRESCALE parameter for simulation
//
// How it works
// - Monitor one silent past its timeout shuts down, raises power error
// - Monitor two does likewise with its own three-bit timeout
// - Monitor one disabled never flags an error or shuts down
// - Monitor two disabled never flags an error or shuts down
// - Monitor one watches port one clock at 0, port two at 1
// - Monitor two picks DAC, ADC or PLL clock; code 3 reserved
// - Monitor one error mutes by hardware at 0, processor at 1
// - Monitor two error ramps DAC gain at 15 to 120 us per dB
// - Recovery bit 0 allows automatic recovery, 1 suppresses it
// - Two-bit field selects PCM rate 8, 16, 48 or 96 kHz
// - Clock loss sets a sticky flag cleared when software reads it
`timescale 1ns/10ps
`include "clk_loss_regs.svh"
module clk_loss_monitor
  import clk_loss_pkg::*;
#(
  parameter int CW       = 24,
  parameter int PRESCALE = 1
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_nrst,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_port_one_clk,
  input  wire logic       i_port_two_clk,
  input  wire logic       i_dac_mod_clk,
  input  wire logic       i_adc_mod_clk,
  input  wire logic       i_pll_clk,
  output logic [7:0]      o_rdata,
  output logic            o_power_error_flag,
  output logic            o_shutdown,
  output logic            o_hw_mute,
  output logic            o_dsp_mute,
  output logic            o_gain_step,
  output logic            o_gain_ramping,
  output logic [1:0]      o_pcm_sample_rate,
  output logic            o_processor_reset_mode
);
  // ****************************************
  // Register file
  // ****************************************
  logic [7:0] ctrl_r, to_one_r, to_two_r, rate_r, rec_r;
  logic       sticky_r;
  logic       lost_one, lost_two, pulse_one, pulse_two;
  logic       src_one, src_two;
  logic [CW-1:0] lim_one, lim_two;
  logic [15:0] ramp_cnt_r;
  logic [15:0] ramp_lim;
  logic       rd_sticky;

  // Software writes; reserved bits kept as written
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_r   <= `RST_MON_CTRL;
      to_one_r <= `RST_TIMEOUT_ONE;
      to_two_r <= `RST_TIMEOUT_TWO;
      rate_r   <= `RST_SAMPLE_RATE;
      rec_r    <= `RST_RECOVERY;
    end else if (i_wr) begin
      unique case (i_addr)
        `OFS_MON_CTRL:    ctrl_r   <= i_wdata;
        `OFS_TIMEOUT_ONE: to_one_r <= i_wdata;
        `OFS_TIMEOUT_TWO: to_two_r <= i_wdata;
        `OFS_SAMPLE_RATE: rate_r   <= i_wdata;
        `OFS_RECOVERY:    rec_r    <= i_wdata;
        default: ;
      endcase
    end
  end

  // Read data registered; unmapped offsets read zero
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      unique case (i_addr)
        `OFS_MON_CTRL:    o_rdata <= ctrl_r;
        `OFS_TIMEOUT_ONE: o_rdata <= to_one_r;
        `OFS_TIMEOUT_TWO: o_rdata <= to_two_r;
        `OFS_SAMPLE_RATE: o_rdata <= rate_r;
        `OFS_RECOVERY:    o_rdata <= rec_r;
        `OFS_STICKY: o_rdata <= {5'h00, sticky_r, 2'h0};
        default:          o_rdata <= 8'h00;
      endcase
    end
  end

  assign rd_sticky = i_rd && (i_addr == `OFS_STICKY);

  // Sticky loss flag; a new loss beats the clearing read
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sticky_r <= 1'b0;
    end else if (pulse_one || pulse_two) begin
      sticky_r <= 1'b1;
    end else if (rd_sticky) begin
      sticky_r <= 1'b0;
    end
  end

  // ****************************************
  // Timeout table and source selection
  // ****************************************
  function automatic logic [CW-1:0] to_cycles(input logic [2:0] code);
    logic [31:0] us;
    us = `TO_US_0;
    unique case (code)
      3'h0: us = `TO_US_0;
      3'h1: us = `TO_US_1;
      3'h2: us = `TO_US_2;
      3'h3: us = `TO_US_3;
      3'h4: us = `TO_US_4;
      3'h5: us = `TO_US_5;
      3'h6: us = `TO_US_6;
      3'h7: us = `TO_US_7;
    endcase
    to_cycles = CW'((us * `CLK_MHZ) / PRESCALE);
  endfunction

  assign lim_one = to_cycles(to_one_r[2:0]);
  assign lim_two = to_cycles(to_two_r[2:0]);

  // Port one or two clock
  assign src_one = ctrl_r[`BIT_SRC_ONE] ? i_port_two_clk
                                        : i_port_one_clk;

  // Reserved code 3 watches nothing and so flags nothing
  always_comb begin
    unique case (ctrl_r[`BIT_SRC_TWO_HI:`BIT_SRC_TWO_LO])
      2'h0:    src_two = i_dac_mod_clk;
      2'h1:    src_two = i_adc_mod_clk;
      2'h2:    src_two = i_pll_clk;
      default: src_two = 1'b0;
    endcase
  end

  // ****************************************
  // Monitors
  // ****************************************
  clk_watch #(.CW(CW)) u_mon_one (
    .i_sys_clk      (i_sys_clk),
    .i_nrst         (i_nrst),
    .i_enable       (ctrl_r[`BIT_EN_ONE]),
    .i_watched      (src_one),
    .i_limit        (lim_one),
    .i_recovery_off (rec_r[`BIT_REC_ONE]),
    .i_release      (i_wr && i_addr == `OFS_RECOVERY),
    .o_lost         (lost_one),
    .o_lost_pulse   (pulse_one)
  );

  clk_watch #(.CW(CW)) u_mon_two (
    .i_sys_clk      (i_sys_clk),
    .i_nrst         (i_nrst),
    .i_enable       (ctrl_r[`BIT_EN_TWO] &&
                     ctrl_r[`BIT_SRC_TWO_HI:`BIT_SRC_TWO_LO] != 2'h3),
    .i_watched      (src_two),
    .i_limit        (lim_two),
    .i_recovery_off (rec_r[`BIT_REC_TWO]),
    .i_release      (i_wr && i_addr == `OFS_RECOVERY),
    .o_lost         (lost_two),
    .o_lost_pulse   (pulse_two)
  );

  // ****************************************
  // Error actions
  // ****************************************
  // Shutdown and power error follow either loss
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_shutdown         <= 1'b0;
      o_power_error_flag <= 1'b0;
    end else begin
      o_shutdown         <= lost_one || lost_two;
      o_power_error_flag <= lost_one || lost_two;
    end
  end

  // Mute path chosen by the mute select bit
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_hw_mute  <= 1'b0;
      o_dsp_mute <= 1'b0;
    end else begin
      o_hw_mute  <= lost_one && !ctrl_r[`BIT_MUTE_SEL];
      o_dsp_mute <= lost_one &&  ctrl_r[`BIT_MUTE_SEL];
    end
  end

  // One gain step of 1 dB per ramp period
  always_comb begin
    unique case (to_two_r[7:6])
      2'h0: ramp_lim = 16'(`RAMP_CYC(`RAMP_US_0));
      2'h1: ramp_lim = 16'(`RAMP_CYC(`RAMP_US_1));
      2'h2: ramp_lim = 16'(`RAMP_CYC(`RAMP_US_2));
      2'h3: ramp_lim = 16'(`RAMP_CYC(`RAMP_US_3));
    endcase
  end

  // Ramp runs while monitor two reports loss; gain block counts steps
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ramp_cnt_r  <= 16'h0000;
      o_gain_step <= 1'b0;
    end else if (!lost_two) begin
      ramp_cnt_r  <= 16'h0000;
      o_gain_step <= 1'b0;
    end else if (ramp_cnt_r == ramp_lim - 16'h0001) begin
      ramp_cnt_r  <= 16'h0000;
      o_gain_step <= 1'b1;
    end else begin
      ramp_cnt_r  <= ramp_cnt_r + 16'h0001;
      o_gain_step <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_gain_ramping <= 1'b0;
    end else begin
      o_gain_ramping <= lost_two;
    end
  end

  assign o_pcm_sample_rate      = rate_r[1:0];
  assign o_processor_reset_mode = ctrl_r[`BIT_RESET_MODE];
endmodule

/* test/clk_sources.sv */
// Purpose: Far-side clock sources for the five watched clock inputs
// Assumes: Each source runs only while its run bit is high
// Notes:   A stopped source freezes at its level, as a halted clock does
`timescale 1ns/10ps
module clk_sources #(
  parameter int HALF = 170
) (
  input  wire logic [4:0] i_run,
  output logic      [4:0] o_clk
);
  // Slow against the system clock so every edge is seen after sync
  initial begin
    o_clk = 5'h00;
    forever #HALF o_clk = o_clk ^ i_run;
  end
endmodule

/* test/clk_loss_monitor_assertions.sv */
// Purpose: Port-level checks of the clock-loss monitor
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Bound from the bench top file
`timescale 1ns/10ps
module clk_loss_monitor_assertions (
  input wire logic       i_sys_clk,
  input wire logic       i_nrst,
  input wire logic       i_wr,
  input wire logic [7:0] i_addr,
  input wire logic       o_power_error_flag,
  input wire logic       o_shutdown,
  input wire logic       o_hw_mute,
  input wire logic       o_dsp_mute,
  input wire logic       o_gain_step,
  input wire logic       o_gain_ramping,
  input wire logic [1:0] o_pcm_sample_rate,
  input wire logic       o_processor_reset_mode
);
  // ****************************************
  // Output relations
  // ****************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  property p_err_shut; o_power_error_flag == o_shutdown; endproperty
  a_err_shut: assert property (p_err_shut)
    else $error("shutdown and error apart");
  property p_mute_one; !(o_hw_mute && o_dsp_mute); endproperty
  a_mute_one: assert property (p_mute_one)
    else $error("both mute paths active");
  property p_mute_shut; (o_hw_mute || o_dsp_mute) |-> o_shutdown; endproperty
  a_mute_shut: assert property (p_mute_shut)
    else $error("mute without shutdown");
  property p_ramp_shut; o_gain_ramping |-> o_shutdown; endproperty
  a_ramp_shut: assert property (p_ramp_shut)
    else $error("ramp without shutdown");
  property p_step_ramp; o_gain_step |-> o_gain_ramping; endproperty
  a_step_ramp: assert property (p_step_ramp)
    else $error("gain step outside ramp");
  // Steps are at least 150 cycles apart, so eight quiet cycles must follow
  property p_step_gap; o_gain_step |=> !o_gain_step [*8]; endproperty
  a_step_gap: assert property (p_step_gap)
    else $error("gain steps too close");
  property p_pcm_wr;
    $changed(o_pcm_sample_rate) |-> $past(i_wr) && $past(i_addr) == 8'h2f;
  endproperty
  a_pcm_wr: assert property (p_pcm_wr)
    else $error("rate changed without write");
  property p_mode_wr;
    $changed(o_processor_reset_mode) |-> $past(i_wr) && $past(i_addr) == 8'h2c;
  endproperty
  a_mode_wr: assert property (p_mode_wr)
    else $error("mode changed without write");
  c_hw: cover property ($rose(o_hw_mute));
  c_dsp: cover property ($rose(o_dsp_mute));
  c_step: cover property (o_gain_step);
endmodule

/* test/clk_loss_monitor_test.sv */
// Purpose: Self-checking bench for the dual clock-loss monitor
// Assumes: Timeouts scaled by PS, ramp periods unscaled
// Notes:   Watched clocks stopped and restarted by the bench
`timescale 1ns/10ps
module clk_loss_monitor_test;
  localparam int PS = 1000;
  logic       i_sys_clk = 1'b0;
  logic       i_nrst, i_wr, i_rd;
  logic [7:0] i_addr, i_wdata, o_rdata, v, d;
  logic [4:0] run, wclk;
  logic       o_power_error_flag, o_shutdown, o_hw_mute, o_dsp_mute;
  logic       o_gain_step, o_gain_ramping, o_processor_reset_mode;
  logic [1:0] o_pcm_sample_rate;
  int         errors, tests_run, seed, n, k, c, rc;
  logic [7:0] ofs[5] = '{8'h2c, 8'h2d, 8'h2e, 8'h2f, 8'h32};
  logic [7:0] rst[5] = '{8'h00, 8'h17, 8'h00, 8'h00, 8'h00};

  clk_loss_monitor #(.PRESCALE(PS)) dut (.i_sys_clk, .i_nrst, .i_wr, .i_rd,
    .i_addr, .i_wdata, .i_port_one_clk(wclk[0]), .i_port_two_clk(wclk[1]),
    .i_dac_mod_clk(wclk[2]), .i_adc_mod_clk(wclk[3]), .i_pll_clk(wclk[4]),
    .o_rdata, .o_power_error_flag, .o_shutdown, .o_hw_mute, .o_dsp_mute,
    .o_gain_step, .o_gain_ramping, .o_pcm_sample_rate,
    .o_processor_reset_mode);
  clk_sources #(.HALF(170)) src (.i_run(run), .o_clk(wclk));
  always #50 i_sys_clk = ~i_sys_clk;

  // ****************************************
  // Expectations and bus tasks
  // ****************************************
  function automatic int tmo(int cd);
    int t[8] = '{2730, 22000, 44000, 87000, 174000, 350000, 700000, 1400000};
    return t[cd] * 10 / PS;
  endfunction
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    tests_run++;
    if (e !== g) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic test_done;
    $display("Checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] dv);
    @(posedge i_sys_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= dv;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  // Extra edge before sampling: read data stands until the next read
  task automatic rd(logic [7:0] a);
    @(posedge i_sys_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    v = o_rdata;
  endtask
  task automatic wt(logic w, int lim);
    for (n = 1; n < lim; n++) begin
      @(negedge i_sys_clk);
      if (o_shutdown === w) return;
    end
    chk("wait_limit", 8'h1, 8'h0);
    test_done;
  endtask
  task automatic wstep;
    for (n = 1; n < 1300; n++) begin
      @(negedge i_sys_clk);
      if (o_gain_step === 1'b1) return;
    end
    chk("step_limit", 8'h1, 8'h0);
    test_done;
  endtask
  // Stopped clocks that are not watched must leave the device running
  task automatic quiet(logic [4:0] stop);
    @(posedge i_sys_clk);
    run <= ~stop;
    repeat (60) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    chk("quiet", 8'h0, 8'(o_shutdown));
    run <= 5'h1f;
  endtask
  // Flags are hw mute, dsp mute and ramping, in that order
  task automatic lose(logic [4:0] stop, int lim, logic [7:0] fl);
    @(posedge i_sys_clk);
    run <= ~stop;
    wt(1'b1, lim + 40);
    chk("loss_time", 8'h1, 8'(n > lim - 6 && n < lim + 10));
    chk("mutes", fl, 8'({o_hw_mute, o_dsp_mute, o_gain_ramping}));
    chk("power_error", 8'h1, 8'(o_power_error_flag));
    if (fl[0]) begin
      wstep;
      wstep;
      chk("step_gap", 8'h1, 8'(n == (150 << rc)));
    end
    run <= 5'h1f;
    wt(1'b0, 40);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    i_nrst    = 1'b0;
    i_wr      = 1'b0;
    i_rd      = 1'b0;
    i_addr    = 8'h00;
    i_wdata   = 8'h00;
    run       = 5'h1f;
    seed      = 16;
    repeat (10) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    for (k = 0; k < 5; k++) begin
      rd(ofs[k]);
      chk("reset_value", rst[k], v);
    end
    for (k = 0; k < 4; k++) begin
      c = $random(seed);
      d = {c[7:2], 2'(k)};
      wr(8'h2f, d);
      rd(8'h2f);
      chk("pcm_reg", d, v);
      chk("pcm_rate", 8'(k), 8'(o_pcm_sample_rate));
    end
    rd(8'h40);
    chk("unmapped", 8'h00, v);
    wr(8'h2c, 8'h80);
    @(negedge i_sys_clk);
    chk("reset_mode", 8'h1, 8'(o_processor_reset_mode));
    wr(8'h2d, 8'h00);
    quiet(5'h1f);
    $display("Test registers and disabled monitors done");
    for (k = 0; k < 2; k++) begin
      c = $random(seed) & 1;
      wr(8'h2c, 8'(2 | k << 4 | c << 5));
      quiet(5'(1 << (1 - k)));
      lose(5'(1 << k), tmo(0), 8'(c ? 2 : 4));
    end
    $display("Test monitor one done");
    wr(8'h2d, 8'h07);
    for (k = 0; k < 3; k++) begin
      rc = $random(seed) & 3;
      c  = (k == 2);
      wr(8'h2e, 8'(rc << 6 | c));
      wr(8'h2c, 8'(1 | k << 2));
      quiet(5'h1c ^ 5'(4 << k));
      lose(5'(4 << k), tmo(c), 8'h01);
    end
    $display("Test monitor two done");
    wr(8'h2d, 8'h00);
    wr(8'h2e, 8'h00);
    // Monitor one on port one, then monitor two on the DAC clock
    for (k = 0; k < 2; k++) begin
      wr(8'h32, 8'(1 << k));
      wr(8'h2c, 8'(2 >> k));
      run <= 5'h1f ^ 5'(1 << (2 * k));
      wt(1'b1, tmo(0) + 40);
      run <= 5'h1f;
      repeat (40) @(posedge i_sys_clk);
      chk("held", 8'h1, 8'(o_shutdown));
      wr(8'h32, 8'h00);
      wt(1'b0, 20);
    end
    rd(8'h68);
    chk("sticky", 8'h04, v & 8'h04);
    rd(8'h68);
    chk("sticky_clr", 8'h00, v & 8'h04);
    $display("Test recovery and sticky flag done");
    test_done;
  end
endmodule

bind clk_loss_monitor clk_loss_monitor_assertions chk_u (.i_sys_clk, .i_nrst,
  .i_wr, .i_addr, .o_power_error_flag, .o_shutdown, .o_hw_mute, .o_dsp_mute,
  .o_gain_step, .o_gain_ramping, .o_pcm_sample_rate,
  .o_processor_reset_mode);
